// >>> core/fsps_seq.sv
// flash self-program sequencer with AHB-Lite register slave
// What this block does
// - buffer loads one word per store
// - buffer words accepted in any order
// - erase pattern plus store within four clocks
// - erase halts core only outside region
// - load pattern stores data pair at word
// - buffer clears after write, reenable, reset
// - eeprom write discards loaded buffer words
// - write pattern plus store programs page
// - write halts core only outside region
// - irq level while enabled and idle
// - region reads blocked during region erase/write
// - busy flag held while region blocked
// - reenable bit clears busy, unblocks reads
// - enable bit clears on done or timeout
// - other control patterns are ignored
// - reenable during loading drops buffer data
// - starting a page load clears busy
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "fsps_params.svh"
module fsps_seq (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        eeprom_write,
  output logic             store_done_irq,
  output logic             cpu_halt,
  output logic             rw_region_read_block,
  output logic             flash_erase_req,
  output logic             flash_write_req,
  output logic [6:0]       flash_page
);
  import fsps_pkg::*;

  fsps_state_t        state;
  fsps_op_t           op;
  logic [7:0]         ctrl;
  logic               busy_flag;
  logic [15:0]        zptr;
  logic [15:0]        data_pair;
  logic [2:0]         arm_cnt;
  logic [15:0]        op_cnt;
  logic [15:0]        buf_mem [`FSPS_WORDS];
  logic [`FSPS_WORDS-1:0] buf_vld;
  logic               loading;
  logic               eep_s1;
  logic               eep_s2;
  logic               eep_d;
  logic               ap_wr;
  logic               ap_rd;
  logic [11:0]        ap_ofs;
  logic               dp_wr;
  logic [11:0]        dp_ofs;
  logic               ctrl_wr;
  logic               cmd_wr;
  logic [4:0]         pat;
  logic               buf_clear;
  logic               eep_pulse;
  logic [6:0]         cmd_page;
  logic               cmd_rww;
  logic               load_store;

  // decoded as a function so address and data phase share it
  function automatic logic is_ofs(input logic [11:0] a, input logic [11:0] o);
    is_ofs = (a == o);
  endfunction : is_ofs

  // address phase capture; ahb-lite zero wait, always okay
  assign ap_wr = hsel && hready && htrans[1] && hwrite;
  assign ap_rd = hsel && hready && htrans[1] && !hwrite;
  assign ap_ofs = haddr[11:0];
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr  <= 1'b0;
      dp_ofs <= 12'h000;
    end else begin
      dp_wr  <= ap_wr;
      dp_ofs <= ap_ofs;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign ctrl_wr = dp_wr && is_ofs(dp_ofs, `FSPS_CTRL_OFS);
  assign cmd_wr  = dp_wr && is_ofs(dp_ofs, `FSPS_CMD_OFS);
  assign pat     = hwdata[4:0];
  assign cmd_page = zptr[15:9];
  assign cmd_rww  = (zptr[15:9] < `FSPS_RWW_PAGES);
  // an armed store carrying the load pattern writes one buffer word
  assign load_store = (state == FSPS_ARMED) && cmd_wr && (ctrl[4:0] == `FSPS_PAT_LOAD);

  // eeprom write strobe arrives from another block: synchronise then edge detect
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      eep_s1 <= 1'b0;
      eep_s2 <= 1'b0;
      eep_d  <= 1'b0;
    end else begin
      eep_s1 <= eeprom_write;
      eep_s2 <= eep_s1;
      eep_d  <= eep_s2;
    end
  end
  assign eep_pulse = eep_s2 && !eep_d;

  // pointer and data pair as loaded by software
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      zptr      <= 16'h0000;
      data_pair <= 16'h0000;
    end else if (dp_wr && is_ofs(dp_ofs, `FSPS_ZPTR_OFS)) begin
      zptr <= hwdata[15:0];
    end else if (dp_wr && is_ofs(dp_ofs, `FSPS_DATA_OFS)) begin
      data_pair <= hwdata[15:0];
    end
  end

  // arming, command execution and completion sequencer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state   <= FSPS_IDLE;
      op      <= FSPS_OP_NONE;
      ctrl    <= `FSPS_CTRL_RST;
      arm_cnt <= 3'h0;
      op_cnt  <= 16'h0000;
    end else begin
      case (state)
        FSPS_IDLE: begin
          if (ctrl_wr) begin
            ctrl[`FSPS_BIT_IE] <= hwdata[`FSPS_BIT_IE];
            // only the five listed patterns arm the window
            if (pat == `FSPS_PAT_LOAD || pat == `FSPS_PAT_ERASE ||
                pat == `FSPS_PAT_WRITE || pat == `FSPS_PAT_REEN ||
                pat == `FSPS_PAT_LOCK) begin
              ctrl[4:0] <= pat;
              state     <= FSPS_ARMED;
              arm_cnt   <= `FSPS_ARM_CYC;
            end
          end
        end
        FSPS_ARMED: begin
          if (cmd_wr) begin
            if (ctrl[`FSPS_BIT_ERS] || ctrl[`FSPS_BIT_WRT]) begin
              state  <= FSPS_BUSY;
              op     <= ctrl[`FSPS_BIT_ERS] ? FSPS_OP_ERASE : FSPS_OP_WRITE;
              op_cnt <= 16'(`FSPS_OP_CYC);
            end else begin
              state     <= FSPS_IDLE;
              ctrl[4:0] <= 5'h00;
            end
          end else if (arm_cnt == 3'h1) begin
            state     <= FSPS_IDLE;
            ctrl[4:0] <= 5'h00;
          end else begin
            arm_cnt <= arm_cnt - 3'h1;
          end
        end
        FSPS_BUSY: begin
          // enable bit stays set until the flash operation ends
          if (op_cnt == 16'h0001) begin
            state     <= FSPS_IDLE;
            op        <= FSPS_OP_NONE;
            ctrl[4:0] <= 5'h00;
          end else begin
            op_cnt <= op_cnt - 16'h0001;
          end
        end
        default: state <= FSPS_IDLE;
      endcase
    end
  end

  // busy flag: set on region erase/write, cleared by reenable or a load
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_flag <= 1'b0;
    end else if (state == FSPS_ARMED && cmd_wr &&
                 (ctrl[`FSPS_BIT_ERS] || ctrl[`FSPS_BIT_WRT]) && cmd_rww) begin
      busy_flag <= 1'b1;
    end else if (state == FSPS_ARMED && cmd_wr &&
                 (ctrl[4:0] == `FSPS_PAT_REEN || ctrl[4:0] == `FSPS_PAT_LOAD)) begin
      busy_flag <= 1'b0;
    end
  end

  // any clear of the page buffer; an armed store is needed for reenable
  assign buf_clear = (state == FSPS_BUSY && op == FSPS_OP_WRITE && op_cnt == 16'h0001) ||
                     (state == FSPS_ARMED && cmd_wr && ctrl[4:0] == `FSPS_PAT_REEN) ||
                     (eep_pulse && loading);

  // loading marks the span from first word until write or clear
  // a new word wins over a discard that falls in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      loading <= 1'b0;
    end else if (load_store) begin
      loading <= 1'b1;
    end else if (buf_clear) begin
      loading <= 1'b0;
    end
  end

  // page buffer words, one flop group per index, random order allowed
  genvar gi;
  generate
    for (gi = 0; gi < `FSPS_WORDS; gi++) begin : g_buf
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          buf_mem[gi] <= 16'hffff;
          buf_vld[gi] <= 1'b0;
        end else if (load_store && zptr[6:1] == `FSPS_WORD_W'(gi)) begin
          buf_mem[gi] <= data_pair;
          buf_vld[gi] <= 1'b1;
        end else if (buf_clear) begin
          buf_mem[gi] <= 16'hffff;
          buf_vld[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // outputs to the core and flash array; a store in idle falls through unused
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      store_done_irq       <= 1'b0;
      cpu_halt             <= 1'b0;
      rw_region_read_block <= 1'b0;
      flash_erase_req      <= 1'b0;
      flash_write_req      <= 1'b0;
      flash_page           <= 7'h00;
    end else begin
      store_done_irq <= ctrl[`FSPS_BIT_IE] && !ctrl[`FSPS_BIT_EN] && state != FSPS_BUSY;
      rw_region_read_block <= busy_flag;
      if (state == FSPS_ARMED && cmd_wr && (ctrl[`FSPS_BIT_ERS] || ctrl[`FSPS_BIT_WRT])) begin
        cpu_halt        <= !cmd_rww;
        flash_erase_req <= ctrl[`FSPS_BIT_ERS];
        flash_write_req <= ctrl[`FSPS_BIT_WRT];
        flash_page      <= cmd_page;
      end else if (state != FSPS_BUSY) begin
        cpu_halt        <= 1'b0;
        flash_erase_req <= 1'b0;
        flash_write_req <= 1'b0;
      end
    end
  end

  // read mux, registered for the data phase
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_rd) begin
      if (is_ofs(ap_ofs, `FSPS_CTRL_OFS)) begin
        hrdata <= {24'h000000, ctrl[7], busy_flag, 1'b0, ctrl[4:0]};
      end else if (is_ofs(ap_ofs, `FSPS_ZPTR_OFS)) begin
        hrdata <= {16'h0000, zptr};
      end else if (is_ofs(ap_ofs, `FSPS_DATA_OFS)) begin
        hrdata <= {16'h0000, data_pair};
      end else if (is_ofs(ap_ofs, `FSPS_STAT_OFS)) begin
        hrdata <= {30'h0, loading, state == FSPS_BUSY};
      end else if (ap_ofs[11:8] == 4'h1) begin
        hrdata <= {15'h0, buf_vld[ap_ofs[7:2]], buf_mem[ap_ofs[7:2]]};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // checks on the sequencer; each guards one rule
  a_arm_timeout: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_ARMED && !cmd_wr && arm_cnt == 3'h1) |=> state == FSPS_IDLE)
    else $error("arm window did not expire");
  a_bad_pat: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_IDLE && ctrl_wr && pat == 5'h07) |=> state == FSPS_IDLE)
    else $error("bad pattern armed");
  a_busy_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_BUSY && op_cnt > 16'h0001 && busy_flag) |=> busy_flag)
    else $error("busy dropped during op");
  a_block_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy_flag |=> rw_region_read_block)
    else $error("region not blocked");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_BUSY) |=> !store_done_irq)
    else $error("irq during op");
  a_buf_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (buf_clear && !load_store) |=> buf_vld == '0)
    else $error("buffer not cleared");
  a_load_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
    load_store
      |=> buf_vld[$past(zptr[6:1])])
    else $error("word not loaded");
  a_idle_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_IDLE && cmd_wr) |=> !flash_erase_req && !flash_write_req)
    else $error("unarmed store acted");
  a_halt_no_read_while_write_region: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_ARMED && cmd_wr && ctrl[`FSPS_BIT_ERS] && !cmd_rww) |=> cpu_halt)
    else $error("core not halted");
  a_halt_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_ARMED && cmd_wr && ctrl[`FSPS_BIT_WRT] && !cmd_rww) |=> cpu_halt)
    else $error("core not halted for write");
  a_busy_rww: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_ARMED && cmd_wr && ctrl[`FSPS_BIT_ERS] && cmd_rww) |=> busy_flag)
    else $error("busy not set for region erase");
  a_reen_busy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_ARMED && cmd_wr && ctrl[4:0] == `FSPS_PAT_REEN) |=> !busy_flag)
    else $error("reenable left busy set");
  a_load_busy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    load_store |=> !busy_flag)
    else $error("load left busy set");
  a_en_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == FSPS_BUSY) |-> ctrl[`FSPS_BIT_EN])
    else $error("enable bit dropped during op");
  // covers for the main scenarios
  c_erase: cover property (@(posedge clk_sys) disable iff (!rst_b) flash_erase_req);
  c_write: cover property (@(posedge clk_sys) disable iff (!rst_b) flash_write_req);
  c_load: cover property (@(posedge clk_sys) disable iff (!rst_b) loading);
  c_timeout: cover property (@(posedge clk_sys) disable iff (!rst_b)
    state == FSPS_ARMED && arm_cnt == 3'h1 && !cmd_wr);
  c_reenable: cover property (@(posedge clk_sys) disable iff (!rst_b)
    state == FSPS_ARMED && cmd_wr && ctrl[4:0] == `FSPS_PAT_REEN);
endmodule : fsps_seq

// >>> core/fsps_params.svh
// register offsets, field positions, reset values and timing counts for the sequencer
`ifndef FSPS_PARAMS_SVH
`define FSPS_PARAMS_SVH
`define FSPS_CTRL_OFS      12'h000
`define FSPS_ZPTR_OFS      12'h004
`define FSPS_DATA_OFS      12'h008
`define FSPS_CMD_OFS       12'h00c
`define FSPS_STAT_OFS      12'h010
`define FSPS_BUF_OFS       12'h100
`define FSPS_CTRL_RST      8'h00
`define FSPS_BIT_EN        0
`define FSPS_BIT_ERS       1
`define FSPS_BIT_WRT       2
`define FSPS_BIT_REEN      4
`define FSPS_BIT_BUSY      6
`define FSPS_BIT_IE        7
`define FSPS_PAT_LOAD      5'h01
`define FSPS_PAT_ERASE     5'h03
`define FSPS_PAT_WRITE     5'h05
`define FSPS_PAT_REEN      5'h11
`define FSPS_PAT_LOCK      5'h09
`define FSPS_ARM_CYC       3'h4
`define FSPS_WORD_W        6
`define FSPS_PAGE_W        7
`define FSPS_WORDS         64
`define FSPS_RWW_PAGES     7'h70
`define FSPS_OP_NS         2000
`define FSPS_CLK_NS        8
`define FSPS_OP_CYC        ((`FSPS_OP_NS) / (`FSPS_CLK_NS))
`endif

// >>> core/fsps_pkg.sv
// types shared by the self-program sequencer
package fsps_pkg;
  typedef enum logic [1:0] {
    FSPS_IDLE,
    FSPS_ARMED,
    FSPS_BUSY
  } fsps_state_t;
  typedef enum logic [1:0] {
    FSPS_OP_NONE,
    FSPS_OP_LOAD,
    FSPS_OP_ERASE,
    FSPS_OP_WRITE
  } fsps_op_t;
endpackage : fsps_pkg

// >>> verif/fsps_core.sv
// core-side model: loader software issuing single-word AHB-Lite transfers
`timescale 1ns/100ps
module fsps_core (
  input  wire logic        clk_sys,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             eeprom_write
);
  // idle bus at time zero; one slave, always selected, word transfers only
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    eeprom_write = 1'b0;
  end

  // the loader sets the interrupt enable with the region erase and the reenable that follows it, and never reads the blocked region
  // address phase held until hready, then the data phase held until hready again
  task automatic xfer(input logic wr, input logic [11:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rd, output logic hung);
    int n;
    htrans <= 2'h2;
    haddr  <= {20'h0, ofs};
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 64);
    hung = (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata; // a read leaves no stale value standing on the lines
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 64);
    hung = hung | (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  // held for several cycles so the two-flop synchroniser surely sees the edge
  task automatic eeprom_pulse();
    eeprom_write <= 1'b1;
    repeat (4) @(posedge clk_sys);
    eeprom_write <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : eeprom_pulse
endmodule : fsps_core

// >>> verif/test_flash_self_program_sequencer.sv
// self-checking bench for the flash self-program sequencer
`timescale 1ns/100ps
`include "fsps_params.svh"
module test_flash_self_program_sequencer;
  logic        clk_sys, rst_b, hsel, hwrite, hready, hresp, eeprom_write;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        irq, halt, blk, ers, wrt;
  logic [6:0]  page;
  int          miscompares, n_compared;

  // the one slave's hreadyout is the bus's hready
  fsps_seq u_fsps_seq (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .eeprom_write(eeprom_write),
    .store_done_irq(irq), .cpu_halt(halt), .rw_region_read_block(blk),
    .flash_erase_req(ers), .flash_write_req(wrt), .flash_page(page));
  fsps_core u_fsps_core (
    .clk_sys(clk_sys), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .eeprom_write(eeprom_write));

  // free-running core clock
  initial clk_sys = 1'b0;
  always #(`FSPS_CLK_NS / 2) clk_sys = ~clk_sys;

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // a wait that ran out is a mismatch and ends the run
  task automatic hang();
    miscompares++;
    $display("MISMATCH t=%0t wait ran out", $time);
    end_sim();
  endtask : hang

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        h;
    u_fsps_core.xfer(1'b1, a, d, r, h);
    if (h) hang();
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    logic [31:0] r;
    logic        h;
    u_fsps_core.xfer(1'b0, a, 32'h0, r, h);
    if (h) hang();
    check(r & m, e, what);
  endtask : rdc

  function automatic logic [11:0] bufa(input logic [5:0] w);
    return `FSPS_BUF_OFS | {4'h0, w, 2'h0};
  endfunction : bufa

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_cyc

  // pointer, control pattern, then the store well inside the four-clock window
  task automatic run(input logic [15:0] z, input logic [7:0] c);
    wr(`FSPS_ZPTR_OFS, {16'h0, z});
    wr(`FSPS_CTRL_OFS, {24'h0, c});
    wr(`FSPS_CMD_OFS, 32'h0);
  endtask : run

  task automatic load(input logic [5:0] w, input logic [15:0] d);
    wr(`FSPS_DATA_OFS, {16'h0, d});
    run({9'h0, w, 1'b0}, 8'h01);
  endtask : load

  // 250-cycle operations; the bound leaves room but still catches a stuck request
  task automatic wait_idle();
    int n;
    n = 0;
    while ((ers | wrt) !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) hang();
  endtask : wait_idle

  task automatic t_reset();
    check({30'h0, hready, hresp}, 32'h2, "bus answer");
    rdc(`FSPS_CTRL_OFS, 32'hff, 32'h0, "ctrl reset");
    rdc(`FSPS_BUF_OFS, 32'h1ffff, 32'h0ffff, "buffer reset");
    check({31'h0, irq}, 32'h0, "irq reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_load();
    load(6'h05, 16'hbeef);
    load(6'h02, 16'h1234);
    rdc(bufa(6'h05), 32'h1ffff, 32'h1beef, "word 5");
    rdc(bufa(6'h02), 32'h1ffff, 32'h11234, "word 2");
    rdc(`FSPS_STAT_OFS, 32'h3, 32'h2, "loading");
    rdc(`FSPS_CTRL_OFS, 32'h1f, 32'h0, "enable after store");
    u_fsps_core.eeprom_pulse();
    rdc(bufa(6'h05), 32'h1ffff, 32'h0ffff, "eeprom drop");
    $display("test load done");
  endtask : t_load

  task automatic t_refuse();
    logic [7:0] bad [3] = '{8'h07, 8'h1f, 8'h15};
    wr(`FSPS_DATA_OFS, 32'h5a5a);
    wr(`FSPS_ZPTR_OFS, 32'he);
    wr(`FSPS_CTRL_OFS, 32'h01);
    wait_cyc(6);
    wr(`FSPS_CMD_OFS, 32'h0); // store lands after the window closed
    rdc(bufa(6'h07), 32'h1ffff, 32'h0ffff, "late store");
    rdc(`FSPS_CTRL_OFS, 32'h1f, 32'h0, "window expiry");
    foreach (bad[i]) begin
      wr(`FSPS_CTRL_OFS, {24'h0, bad[i]});
      rdc(`FSPS_CTRL_OFS, 32'h1f, 32'h0, "bad pattern");
    end
    wr(`FSPS_CMD_OFS, 32'h0);
    wait_cyc(2);
    check({30'h0, ers, wrt}, 32'h0, "store unarmed");
    wr(`FSPS_CTRL_OFS, 32'h09);
    rdc(`FSPS_CTRL_OFS, 32'h1f, 32'h09, "lock pattern");
    wr(`FSPS_CMD_OFS, 32'h0); // the lock store lands on the last edge of the window
    rdc(`FSPS_CTRL_OFS, 32'h1f, 32'h0, "lock done");
    rdc(bufa(6'h07), 32'h1ffff, 32'h0ffff, "lock no load");
    check({30'h0, ers, wrt}, 32'h0, "lock no op");
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_erase_rww();
    run({7'h03, 9'h0}, 8'h83);
    wait_cyc(2);
    check({29'h0, ers, halt, blk}, 32'h5, "rww erase");
    check({25'h0, page}, 32'h3, "erase page");
    check({31'h0, irq}, 32'h0, "irq busy");
    rdc(`FSPS_CTRL_OFS, 32'h41, 32'h41, "busy running");
    rdc(`FSPS_STAT_OFS, 32'h1, 32'h1, "op running");
    wait_idle();
    rdc(`FSPS_CTRL_OFS, 32'h41, 32'h40, "busy kept");
    check({31'h0, irq}, 32'h1, "irq when done");
    check({31'h0, blk}, 32'h1, "still blocked");
    run(16'h0, 8'h91);
    wait_cyc(2);
    check({30'h0, blk, irq}, 32'h1, "reenabled");
    $display("test erase_rww done");
  endtask : t_erase_rww

  task automatic t_no_read_while_write_region();
    load(6'h01, 16'ha5a5);
    run({7'h70, 9'h0}, 8'h03);
    wait_cyc(2);
    check({31'h0, halt}, 32'h1, "erase halt");
    wait_idle();
    run({7'h70, 9'h0}, 8'h05);
    wait_cyc(2);
    check({24'h0, wrt, page}, 32'hf0, "write page");
    check({31'h0, halt}, 32'h1, "write halt");
    wait_idle();
    rdc(bufa(6'h01), 32'h1ffff, 32'h0ffff, "cleared by write");
    $display("test no_read_while_write_region done");
  endtask : t_no_read_while_write_region

  task automatic t_rww_write();
    run({7'h03, 9'h0}, 8'h05);
    wait_cyc(2);
    check({29'h0, wrt, halt, blk}, 32'h5, "rww write");
    wait_idle();
    load(6'h04, 16'h0f0f);
    wait_cyc(2);
    check({31'h0, blk}, 32'h0, "load clears busy");
    run(16'h0, 8'h11);
    rdc(bufa(6'h04), 32'h1ffff, 32'h0ffff, "reenable drop");
    $display("test rww_write done");
  endtask : t_rww_write

  // reset for 16 cycles, then the scenarios in turn
  initial begin
    miscompares = 0;
    n_compared = 0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk_sys);
    check({31'h0, hready}, 32'h0, "ready in reset");
    rst_b <= 1'b1;
    wait_cyc(3);
    t_reset();
    t_load();
    t_refuse();
    t_erase_rww();
    t_no_read_while_write_region();
    t_rww_write();
    end_sim();
  end
endmodule : test_flash_self_program_sequencer
